// ==== common/eif_pkg.sv ====
// Constants for the external interrupt filter block.
// Assumes a single 50 MHz clock; high and low clock rates arrive as enables.
package eif_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned NUM_IRQ = 5;
  localparam logic [7:0] CTRL_ADDR = 8'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control register bit positions
  localparam int unsigned B_NOISE_SEL = 7;
  localparam int unsigned B_PIN_SEL = 6;
  localparam int unsigned B_C_MODE = 4;
  localparam int unsigned B_D_MODE = 2;
  localparam int unsigned B_B_EDGE = 1;
  // Acceptance counts in high-frequency clock periods
  localparam logic [7:0] ACC_AE = 8'h07;
  localparam logic [7:0] ACC_B_LONG = 8'hC1;
  localparam logic [7:0] ACC_B_SHORT = 8'h31;
  localparam logic [7:0] ACC_CD = 8'h19;
  // Low-frequency acceptance: 3.5 periods, counted as 4 whole periods
  localparam logic [7:0] ACC_LOW = 8'h04;
  // Detect mode encodings
  localparam logic [1:0] MODE_RISE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_BOTH = 2'h2;
  localparam logic [1:0] MODE_HIGH = 2'h3;
  typedef enum logic [1:0] {
    EIF_ARM_WAIT = 2'b01,
    EIF_ARM_READY = 2'b10
  } eif_arm_t;
endpackage : eif_pkg

// ==== verilog/eif_filter.sv ====
// External interrupt conditioner: five filtered inputs setting latches.
// Assumes hf_tick/lf_tick are one-cycle enables of the active clocks and
// that the core pulses irq_ack to clear a latch on acceptance.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Five inputs, each with own noise filter
// - Pin select bit: port or interrupt a
// - Inputs a,e falling edge, 2/7 cycles
// - Input b rejection 63 or 15 cycles
// - Input b accepts after 49 or 193
// - Inputs c,d reject 7, accept 25
// - Low-speed modes: 1 reject, 3.5 accept, counted as 4
// - Inputs c,d: rise, fall, both, high
// - Latch set within acceptance plus six
// - Noise select change effective within 26
// - High level waits for rising edge
// - Output pin changes may raise requests
// - Acceptance clears the source latch
module eif_filter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hf_tick,
  input wire logic lf_tick,
  input wire logic low_speed,
  input wire logic [4:0] irq_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic master_irq_enable,
  input wire logic [4:0] irq_enable_flag,
  input wire logic irq_c_latch_enable,
  input wire logic [4:0] irq_ack,
  output logic [4:0] irq_latch,
  output logic [4:0] irq_request,
  output logic [4:0] filt_level,
  output logic shared_pin_is_irq
);
  // Acceptance count for one input at the current clock rate
  function automatic logic [7:0] acc_count(input int unsigned idx,
      input logic low, input logic nsel);
    logic [7:0] c;
    c = eif_pkg::ACC_CD;
    if (idx == 0 || idx == 4) begin
      c = eif_pkg::ACC_AE;
    end else if (idx == 1) begin
      c = nsel ? eif_pkg::ACC_B_SHORT : eif_pkg::ACC_B_LONG;
    end
    if (low) begin
      c = eif_pkg::ACC_LOW;
    end
    return c;
  endfunction : acc_count

  // Control register; noise select applies on the next tick
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = (reg_addr == eif_pkg::CTRL_ADDR) ? ctrl_r : 8'h00;
    if (reg_wr && reg_addr == eif_pkg::CTRL_ADDR) begin
      ctrl_nxt = reg_wdata;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= eif_pkg::CTRL_RESET;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // Two-stage synchroniser: pins are asynchronous to mclk
  logic [4:0] sync1_r, sync2_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= irq_pin;
      sync2_r <= sync1_r;
    end
  end

  logic [4:0] lvl_r;
  logic [4:0] det;
  logic tick;
  assign tick = low_speed ? lf_tick : hf_tick;

  // Synchroniser output is only trusted two edges after reset release;
  // before that it still shows its reset zeros rather than the pin
  logic [1:0] alive_r, alive_nxt;
  always_comb begin
    alive_nxt = {alive_r[0], 1'b1};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alive_r <= 2'h0;
    end else begin
      alive_r <= alive_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < eif_pkg::NUM_IRQ; gi++) begin : g_in
      logic [7:0] cnt_r, cnt_nxt;
      logic lvl_q, lvl_nxt;
      logic prev_r, prev_nxt;
      logic low_seen_r, low_seen_nxt;
      eif_pkg::eif_arm_t arm_r, arm_nxt;
      logic [1:0] mode;
      logic rise, fall, det_v;
      always_comb begin
        cnt_nxt = cnt_r;
        lvl_nxt = lvl_q;
        if (tick) begin
          if (sync2_r[gi] == lvl_q) begin
            cnt_nxt = 8'h00;
          end else if (cnt_r + 8'h01 >= acc_count(gi, low_speed,
              ctrl_r[eif_pkg::B_NOISE_SEL])) begin
            // Short glitches restart the count and never get here
            cnt_nxt = 8'h00;
            lvl_nxt = sync2_r[gi];
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
      end
      // A pin held high through reset must not pass for a rising edge
      assign low_seen_nxt = low_seen_r | (alive_r[1] & ~sync2_r[gi]);
      // Edge detectors work on the filtered level; rise is also gated by low_seen_r
      assign prev_nxt = lvl_q;
      assign rise = lvl_q & ~prev_r & low_seen_r;
      assign fall = ~lvl_q & prev_r;
      assign mode = (gi == 2) ? ctrl_r[eif_pkg::B_C_MODE +: 2] :
                    ctrl_r[eif_pkg::B_D_MODE +: 2];
      // High level counts only after a rising edge since reset
      always_comb begin
        arm_nxt = arm_r;
        case (arm_r)
          eif_pkg::EIF_ARM_WAIT: if (rise) arm_nxt = eif_pkg::EIF_ARM_READY;
          eif_pkg::EIF_ARM_READY: arm_nxt = eif_pkg::EIF_ARM_READY;
          default: arm_nxt = eif_pkg::EIF_ARM_WAIT;
        endcase
      end
      always_comb begin
        det_v = fall;
        if (gi == 1) begin
          det_v = ctrl_r[eif_pkg::B_B_EDGE] ? fall : rise;
        end else if (gi == 2 || gi == 3) begin
          case (mode)
            eif_pkg::MODE_RISE: det_v = rise;
            eif_pkg::MODE_FALL: det_v = fall;
            eif_pkg::MODE_BOTH: det_v = rise | fall;
            eif_pkg::MODE_HIGH: det_v = lvl_q &&
                arm_r == eif_pkg::EIF_ARM_READY;
            default: det_v = 1'b0;
          endcase
        end
      end
      assign det[gi] = det_v;
      assign lvl_r[gi] = lvl_q;
      // Filter level resets low; only a rise after a seen low arms level mode
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cnt_r <= 8'h00;
          lvl_q <= 1'b0;
          prev_r <= 1'b0;
          low_seen_r <= 1'b0;
          arm_r <= eif_pkg::EIF_ARM_WAIT;
        end else begin
          cnt_r <= cnt_nxt;
          lvl_q <= lvl_nxt;
          prev_r <= prev_nxt;
          low_seen_r <= low_seen_nxt;
          arm_r <= arm_nxt;
        end
      end
    end
  endgenerate

  // Latches: set wins over acceptance clear; detector sees the pin even
  // when driven as output, so software must mask meanwhile
  logic [4:0] latch_r, latch_nxt, set_v, req_nxt, req_r, en_v;
  logic pin_r;
  always_comb begin
    set_v = det;
    set_v[0] = det[0] & ctrl_r[eif_pkg::B_PIN_SEL];
    latch_nxt = (latch_r & ~irq_ack) | set_v;
    en_v = irq_enable_flag & {5{master_irq_enable}};
    en_v[0] = en_v[0] & ctrl_r[eif_pkg::B_PIN_SEL];
    en_v[2] = en_v[2] & irq_c_latch_enable;
    req_nxt = latch_nxt & en_v;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch_r <= 5'h00;
      req_r <= 5'h00;
      pin_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      req_r <= req_nxt;
      pin_r <= ctrl_nxt[eif_pkg::B_PIN_SEL];
    end
  end
  assign irq_latch = latch_r;
  assign irq_request = req_r;
  assign filt_level = lvl_r;
  assign shared_pin_is_irq = pin_r;
endmodule : eif_filter
`default_nettype wire

// ==== verif/eif_pin_src.sv ====
// Pin source model for the five interrupt inputs.
// Assumes pulse() is called just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module eif_pin_src (
  input wire logic mclk,
  output var logic [4:0] irq_pin
);
  // Idle: a and e high, others low; pins are inputs only
  initial irq_pin = 5'h11;
  // Pins are async, so restore timing need not be edge-exact
  task automatic pulse(input int idx, input int wid);
    irq_pin[idx] = ~irq_pin[idx];
    repeat (wid) @(posedge mclk);
    #1 irq_pin[idx] = ~irq_pin[idx];
  endtask : pulse
endmodule : eif_pin_src
`default_nettype wire

// ==== verif/eif_filter_properties.sv ====
// Port checker for the interrupt conditioner.
// Assumes hf_tick stays high whenever low_speed is low.
`timescale 1ns/10ps
`default_nettype none
module eif_filter_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic low_speed,
  input wire logic [4:0] irq_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic master_irq_enable,
  input wire logic [4:0] irq_enable_flag,
  input wire logic irq_c_latch_enable,
  input wire logic [4:0] irq_ack,
  input wire logic [4:0] irq_latch,
  input wire logic [4:0] irq_request,
  input wire logic [4:0] filt_level,
  input wire logic shared_pin_is_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  localparam logic [7:0] acc_min [5] = '{8'h07, 8'h31, 8'h19, 8'h19, 8'h07};
  logic [4:0] pin_q;
  logic [4:0] en;
  logic [7:0] cnt [5];
  assign en = {5{master_irq_enable}} & irq_enable_flag
    & {2'h3, irq_c_latch_enable, 2'h3};
  // Cycles since each raw pin last moved, saturating
  always_ff @(posedge mclk or posedge rst) begin
    pin_q <= rst ? 5'h00 : irq_pin;
    for (int i = 0; i < 5; i++) begin
      cnt[i] <= (rst || irq_pin[i] != pin_q[i]) ? 8'h00 :
        cnt[i] + {7'h00, cnt[i] != 8'hFF};
    end
  end
  for (genvar i = 0; i < 5; i++) begin : g_pin
    chk_filter_reject: assert property ($changed(filt_level[i]) |->
      cnt[i] >= (low_speed ? 8'h04 : acc_min[i])) else $error("early change");
    // Slack of six covers the pin synchroniser; input b is left out
    chk_filter_accept: assert property (i != 1 && !low_speed &&
      cnt[i] == acc_min[i] + 8'h06 |-> filt_level[i] == irq_pin[i])
      else $error("stable pin not passed");
  end
  chk_latch_sticky: assert property (1'b1 |=>
    ($past(irq_latch) & ~$past(irq_ack) & ~irq_latch) == 5'h00)
    else $error("latch dropped");
  chk_ack_clears: assert property (irq_ack[0] && !$fell(filt_level[0])
    |=> !irq_latch[0]) else $error("latch not cleared");
  chk_req_gate: assert property (1'b1 |=> (irq_request & 5'h1E) ==
    (irq_latch & $past(en) & 5'h1E)) else $error("request gating");
  chk_a_gate: assert property ($rose(irq_latch[0]) |->
    shared_pin_is_irq) else $error("port pin latched");
  chk_a_falling: assert property ($rose(irq_latch[0]) |->
    !$past(filt_level[0]) && $past(filt_level[0], 2))
    else $error("latch a without fall");
  chk_rd_unmapped: assert property (reg_addr != 8'h37 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : eif_filter_properties
`default_nettype wire

// ==== verif/eif_filter_bench.sv ====
// Bench: table of pin pulses, then register, gating and low-speed cases.
// Assumes pins come from eif_pin_src and the checker is bound below.
`timescale 1ns/10ps
`default_nettype none
module eif_filter_bench;
  typedef struct {int idx; logic [7:0] ctl; int wid; logic mid, late;} eif_row_t;
  logic mclk, rst, hf_tick, lf_tick, low_speed, reg_wr, master, c_le, pin_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [4:0] irq_pin, flags, irq_ack, irq_latch, irq_request, filt_level;
  int err_total = 0, compares = 0;
  eif_row_t rows [13] = '{'{0, 8'h40, 60, 1, 0}, '{0, 8'h00, 60, 0, 0},
    '{0, 8'h40, 1, 0, 0}, '{4, 8'h00, 60, 1, 0}, '{1, 8'h80, 60, 1, 0},
    '{1, 8'h82, 60, 0, 1}, '{1, 8'h00, 100, 0, 0}, '{2, 8'h00, 40, 1, 0},
    '{2, 8'h10, 40, 0, 1}, '{2, 8'h20, 40, 1, 1}, '{2, 8'h30, 40, 1, 1},
    '{2, 8'h20, 5, 0, 0}, '{3, 8'h0C, 40, 1, 1}};
  `define EIF_CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  eif_filter DUT (.mclk(mclk), .rst(rst), .hf_tick(hf_tick), .lf_tick(lf_tick),
    .low_speed(low_speed), .irq_pin(irq_pin), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .master_irq_enable(master), .irq_enable_flag(flags),
    .irq_c_latch_enable(c_le), .irq_ack(irq_ack), .irq_latch(irq_latch),
    .irq_request(irq_request), .filt_level(filt_level),
    .shared_pin_is_irq(pin_irq));
  eif_pin_src src (.mclk(mclk), .irq_pin(irq_pin));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // Slow clock enable every sixth cycle, only in low-speed mode
  initial forever begin
    lf_tick = 1'b0;
    cyc(5);
    lf_tick = low_speed;
    cyc(1);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    cyc(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    cyc(1);
    `EIF_CHK(reg_rdata, e)
  endtask : rd
  task automatic ack();
    irq_ack = 5'h1F;
    cyc(1);
    irq_ack = 5'h00;
  endtask : ack
  task automatic finish_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    {rst, hf_tick, low_speed, reg_wr, master, c_le} = 6'h33;
    {reg_addr, reg_wdata, flags, irq_ack} = {16'h0000, 5'h1F, 5'h00};
    cyc(20);
    rst = 1'b0;
    `EIF_CHK({irq_latch, pin_irq}, 6'h00)
    rd(8'h37, 8'h00);
    cyc(300);
    `EIF_CHK(filt_level, 5'h11)
    foreach (rows[i]) begin
      master = 1'b0;
      wr(8'h37, rows[i].ctl);
      cyc(30);
      master = 1'b1;
      src.pulse(rows[i].idx, rows[i].wid);
      `EIF_CHK(irq_latch[rows[i].idx], rows[i].mid)
      ack();
      cyc(80);
      `EIF_CHK(irq_latch[rows[i].idx], rows[i].late)
      ack();
    end
    c_le = 1'b0;
    src.pulse(2, 40);
    `EIF_CHK({irq_latch[2], irq_request[2]}, 2'h2)
    c_le = 1'b1;
    cyc(2);
    `EIF_CHK(irq_request[2], 1'b1)
    ack();
    cyc(60);
    wr(8'h37, 8'hFF);
    rd(8'h37, 8'hFF);
    `EIF_CHK(pin_irq, 1'b1)
    wr(8'h36, 8'h00);
    rd(8'h36, 8'h00);
    wr(8'h37, 8'h00);
    ack();
    {hf_tick, low_speed} = 2'h1;
    src.pulse(2, 2);
    cyc(40);
    `EIF_CHK(irq_latch[2], 1'b0)
    src.pulse(2, 40);
    `EIF_CHK(irq_latch[2], 1'b1)
    cyc(60);
    {hf_tick, low_speed} = 2'h2;
    cyc(10);
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    finish_test();
  end
endmodule : eif_filter_bench
bind eif_filter eif_filter_properties chk (.mclk(mclk), .rst(rst),
  .low_speed(low_speed), .irq_pin(irq_pin), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .master_irq_enable(master_irq_enable),
  .irq_enable_flag(irq_enable_flag), .irq_c_latch_enable(irq_c_latch_enable),
  .irq_ack(irq_ack), .irq_latch(irq_latch), .irq_request(irq_request),
  .filt_level(filt_level), .shared_pin_is_irq(shared_pin_is_irq));
`default_nettype wire
